// ==== bsa_params.svh ====
`ifndef BSA_PARAMS_SVH
`define BSA_PARAMS_SVH

// =====================================
// widths and field positions
`define BSA_DATA_W 32
`define BSA_HALF_W 16
`define BSA_ADDR_W 30
`define BSA_BE_W 4
// =====================================
// byte enable values
`define BSA_BE_ALL_OFF 4'hF
`define BSA_BE_LOW_OFF 4'h3
`define BSA_PAIR_OFF 2'h3

`endif

// ==== bsa_pkg.sv ====
`include "bsa_params.svh"

package bsa_pkg;

   // =====================================
   // request from the core side
   typedef struct packed {
      logic write;
      logic [`BSA_ADDR_W-1:0] addr;
      logic [`BSA_BE_W-1:0] be_n;
      logic [`BSA_DATA_W-1:0] wdata;
   } bsa_req_t;

   // =====================================
   // bus sequencer states
   typedef enum logic [1:0] {
      S_IDLE = 2'h0,
      S_T1 = 2'h1,
      S_T2 = 2'h3
   } bsa_state_t;

endpackage

// ==== bsa_be_convert.sv ====
`timescale 1ns/1ps
`include "bsa_params.svh"

module bsa_be_convert
   import bsa_pkg::*;
(
   input wire logic [`BSA_BE_W-1:0] be_n,
   output logic upper_byte_enable_n,
   output logic lower_byte_enable_n,
   output logic word_select_bit
);

   // =====================================
   // combinational lane mapping, unused patterns fall where they fall
   wire odd_word = be_n[0] & be_n[1];
   assign word_select_bit = odd_word;
   assign lower_byte_enable_n = odd_word ? be_n[2] : be_n[0];
   assign upper_byte_enable_n = odd_word ? be_n[3] : be_n[1];

endmodule // bsa_be_convert

// ==== bsa_adapter.sv ====
// Notes on behaviour
// - upper-only write copies upper half to lower
// - half-width upper read takes data from lower lanes
// - half-width cycle spanning both halves splits
// - second cycle repeats, lower enables forced off
// - second write cycle carries upper data low
// - writes drive the whole data bus
// - empty or gapped enable patterns passed on from req.be_n unchanged, only flagged by a_be_valid
// - half-width select ignored when upper enables off
`timescale 1ns/1ps
`include "bsa_params.svh"

module bsa_adapter
   import bsa_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic req_valid,
   input wire bsa_req_t req,
   output logic req_ready_r,
   output logic done_r,
   output logic [`BSA_DATA_W-1:0] done_rdata_r,
   output logic cycle_start_n_r,
   output logic bus_write_r,
   output logic [`BSA_ADDR_W-1:0] bus_addr_r,
   output logic [`BSA_BE_W-1:0] bus_be_n_r,
   output logic [`BSA_DATA_W-1:0] bus_dout_r,
   output logic bus_doe_r,
   output logic upper_byte_enable_n_r,
   output logic lower_byte_enable_n_r,
   output logic word_select_bit_r,
   input wire logic [`BSA_DATA_W-1:0] bus_din,
   input wire logic bus_ready_n,
   input wire logic half_width_bus_select_n
);

   // =====================================
   // pin synchronisers
   logic [`BSA_DATA_W-1:0] din_s1, din_s2;
   logic rdy_s1, rdy_s2, bs_s1, bs_s2;

   always_ff @(posedge clock) begin
      din_s1 <= bus_din;
      din_s2 <= din_s1;
      rdy_s1 <= bus_ready_n;
      rdy_s2 <= rdy_s1;
      bs_s1 <= half_width_bus_select_n;
      bs_s2 <= bs_s1;
   end

   // =====================================
   // decode
   bsa_state_t state_r, state_nxt;
   logic second_r;
   logic [`BSA_HALF_W-1:0] lo_hold_r;

   wire lo_act = ~&bus_be_n_r[1:0];
   wire hi_act = ~&bus_be_n_r[`BSA_BE_W-1:2];
   wire bs_on = ~bs_s2;
   wire ready_hit = (state_r == S_T2) && !rdy_s2;
   wire split_go = ready_hit && bs_on && lo_act && hi_act && !second_r;
   wire finish = ready_hit && !split_go;
   wire accept = (state_r == S_IDLE) && req_valid && req_ready_r;

   wire [`BSA_HALF_W-1:0] req_hi = req.wdata[`BSA_DATA_W-1:`BSA_HALF_W];
   wire [`BSA_HALF_W-1:0] dout_hi = bus_dout_r[`BSA_DATA_W-1:`BSA_HALF_W];
   wire req_dup = (req.be_n[1:0] == `BSA_PAIR_OFF);

   wire [`BSA_BE_W-1:0] be_nxt = accept ? req.be_n :
      split_go ? (bus_be_n_r | `BSA_BE_LOW_OFF) :
      finish ? `BSA_BE_ALL_OFF : bus_be_n_r;
   wire [`BSA_DATA_W-1:0] dout_nxt = accept ? (req_dup ? {req_hi, req_hi} : req.wdata) :
      split_go ? {dout_hi, dout_hi} : bus_dout_r;
   wire doe_nxt = accept ? req.write : (finish ? 1'b0 : bus_doe_r);
   wire second_nxt = accept ? 1'b0 : (split_go ? 1'b1 : second_r);

   wire [`BSA_HALF_W-1:0] rd_hi = (bs_on && !lo_act) ? din_s2[`BSA_HALF_W-1:0] :
      din_s2[`BSA_DATA_W-1:`BSA_HALF_W];
   wire [`BSA_HALF_W-1:0] rd_lo = second_r ? lo_hold_r : din_s2[`BSA_HALF_W-1:0];

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: if (accept) state_nxt = S_T1;
         S_T1: state_nxt = S_T2;
         S_T2: begin
            if (split_go) state_nxt = S_T1;
            else if (finish) state_nxt = S_IDLE;
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   // =====================================
   // lane converter on the next enables, registered with them
   logic ube_nxt, lbe_nxt, wsb_nxt;

   bsa_be_convert u_conv (
      .be_n(be_nxt),
      .upper_byte_enable_n(ube_nxt),
      .lower_byte_enable_n(lbe_nxt),
      .word_select_bit(wsb_nxt)
   );

   // =====================================
   // sequencer and bus registers
   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_r <= S_IDLE;
         second_r <= 1'b0;
         req_ready_r <= 1'b0;
         cycle_start_n_r <= 1'b1;
         bus_be_n_r <= `BSA_BE_ALL_OFF;
         bus_doe_r <= 1'b0;
         upper_byte_enable_n_r <= 1'b1;
         lower_byte_enable_n_r <= 1'b1;
         word_select_bit_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         second_r <= second_nxt;
         req_ready_r <= (state_nxt == S_IDLE);
         cycle_start_n_r <= !(accept || split_go);
         bus_be_n_r <= be_nxt;
         bus_doe_r <= doe_nxt;
         upper_byte_enable_n_r <= ube_nxt;
         lower_byte_enable_n_r <= lbe_nxt;
         word_select_bit_r <= wsb_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         bus_write_r <= 1'b0;
         bus_addr_r <= '0;
         bus_dout_r <= '0;
      end else if (accept) begin
         bus_write_r <= req.write;
         bus_addr_r <= req.addr;
         bus_dout_r <= dout_nxt;
      end else begin
         bus_dout_r <= dout_nxt;
      end
   end

   // =====================================
   // transfer completion and read data
   always_ff @(posedge clock) begin
      if (!nrst) begin
         done_r <= 1'b0;
         done_rdata_r <= '0;
         lo_hold_r <= '0;
      end else begin
         done_r <= finish;
         if (finish) done_rdata_r <= {rd_hi, rd_lo};
         if (split_go) lo_hold_r <= din_s2[`BSA_HALF_W-1:0];
      end
   end

   // =====================================
   // checks
   wire split_cond = ready_hit && bs_on && lo_act && hi_act && !second_r;

   property p_dup_upper;
      @(posedge clock) disable iff (!nrst)
      (bus_doe_r && bus_be_n_r[1:0] == `BSA_PAIR_OFF && hi_act) |-> (bus_dout_r[15:0] == bus_dout_r[31:16]);
   endproperty
   a_dup_upper: assert property (p_dup_upper) else $error("upper half not copied low");

   property p_rd_upper;
      @(posedge clock) disable iff (!nrst)
      (ready_hit && bs_on && !lo_act && hi_act && !bus_write_r) |=>
         (done_r && done_rdata_r[31:16] == $past(din_s2[15:0]));
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read not taken from low lanes");

   property p_split;
      @(posedge clock) disable iff (!nrst)
      split_cond |=> (state_r == S_T1 && second_r && !cycle_start_n_r && !done_r) ##1 (state_r == S_T2);
   endproperty
   a_split: assert property (p_split) else $error("spanning cycle did not split");

   property p_second_be;
      @(posedge clock) disable iff (!nrst)
      split_cond |=> (bus_be_n_r == ($past(bus_be_n_r) | 4'h3) && bus_addr_r == $past(bus_addr_r)
         && bus_write_r == $past(bus_write_r));
   endproperty
   a_second_be: assert property (p_second_be) else $error("second cycle differs from first");

   property p_split_wdata;
      @(posedge clock) disable iff (!nrst)
      (split_cond && bus_write_r) |=> (bus_dout_r[15:0] == $past(bus_dout_r[31:16]) && bus_doe_r);
   endproperty
   a_split_wdata: assert property (p_split_wdata) else $error("second write lacks upper data");

   property p_wr_drive;
      @(posedge clock) disable iff (!nrst)
      (bus_write_r && state_r != S_IDLE) |-> bus_doe_r;
   endproperty
   a_wr_drive: assert property (p_wr_drive) else $error("write cycle not driving data");

   property p_upper_off_single;
      @(posedge clock) disable iff (!nrst)
      (ready_hit && !hi_act) |=> (done_r && state_r == S_IDLE);
   endproperty
   a_upper_off_single: assert property (p_upper_off_single) else $error("lower-only cycle was split");

   property p_be_valid;
      @(posedge clock) disable iff (!nrst)
      !cycle_start_n_r |-> ((~bus_be_n_r) inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'hC, 4'hE, 4'hF});
   endproperty
   a_be_valid: assert property (p_be_valid) else $error("invalid byte enable pattern issued");

   property p_cv_split_wr;
      @(posedge clock) disable iff (!nrst)
      split_cond && bus_write_r;
   endproperty
   c_cv_split_wr: cover property (p_cv_split_wr);

   property p_cv_split_rd;
      @(posedge clock) disable iff (!nrst)
      split_cond && !bus_write_r;
   endproperty
   c_cv_split_rd: cover property (p_cv_split_rd);

   property p_cv_upper_rd;
      @(posedge clock) disable iff (!nrst)
      ready_hit && bs_on && !lo_act && !bus_write_r;
   endproperty
   c_cv_upper_rd: cover property (p_cv_upper_rd);

endmodule // bsa_adapter

// ==== bsa_mem16_model.sv ====
`timescale 1ns/1ps
`include "bsa_params.svh"
// ====
// device on the far side, 16-bit when size16 is set, else 32-bit
module bsa_mem16_model (
   input wire logic clock,
   input wire logic cycle_start_n,
   input wire logic word_select_bit,
   input wire logic size16,
   input wire logic [1:0] waits,
   input wire logic [`BSA_DATA_W-1:0] mem,
   output logic [`BSA_DATA_W-1:0] bus_din,
   output logic bus_ready_n,
   output logic half_width_bus_select_n
);
   logic [2:0] cnt_r;
   logic [15:0] half;
   assign half = word_select_bit ? mem[31:16] : mem[15:0];
   initial begin
      cnt_r = 3'h0;
      bus_din = 32'h0;
      bus_ready_n = 1'b1;
      half_width_bus_select_n = 1'b1;
   end
   always @(negedge clock) begin
      bus_ready_n <= 1'b1;
      half_width_bus_select_n <= 1'b1;
      bus_din <= ~bus_din;
      if (!cycle_start_n) begin
         cnt_r <= {1'b0, waits} + 3'h1;
      end else if (cnt_r == 3'h1) begin
         bus_ready_n <= 1'b0;
         half_width_bus_select_n <= ~size16;
         bus_din <= size16 ? {~half, half} : mem;
         cnt_r <= 3'h0;
      end else if (cnt_r != 3'h0) begin
         cnt_r <= cnt_r - 3'h1;
      end
   end
endmodule // bsa_mem16_model

// ==== bus_sizing_16bit_adapter_tb_top.sv ====
`timescale 1ns/1ps
`include "bsa_params.svh"
// ====
// bench
module bus_sizing_16bit_adapter_tb_top import bsa_pkg::*;;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   logic size16 = 1'b0;
   logic [1:0] waits = 2'h0;
   bsa_req_t req = '0;
   logic req_ready_r, done_r, cycle_start_n_r, bus_doe_r, up_n, lo_n, ws, bus_ready_n, bs_n;
   logic [3:0] bus_be_n_r;
   logic bus_write_r;
   logic [29:0] bus_addr_r;
   logic [31:0] done_rdata_r, bus_dout_r, bus_din;
   logic [31:0] mem = 32'h5A6B7C8D;
   logic [39:0] q[$];
   logic [30:0] qa[$];
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   // {be_n, word_select, upper_n, lower_n} of every pattern issued
   localparam logic [6:0] TBL [10] = '{7'h72, 7'h69, 7'h60, 7'h5E, 7'h49,
      7'h40, 7'h3D, 7'h1C, 7'h09, 7'h00};
   always #20 clock = ~clock;
   bsa_adapter DUT (.clock(clock), .nrst(nrst), .req_valid(req_valid), .req(req),
      .req_ready_r(req_ready_r), .done_r(done_r), .done_rdata_r(done_rdata_r),
      .cycle_start_n_r(cycle_start_n_r), .bus_write_r(bus_write_r), .bus_addr_r(bus_addr_r),
      .bus_be_n_r(bus_be_n_r),
      .bus_dout_r(bus_dout_r), .bus_doe_r(bus_doe_r), .upper_byte_enable_n_r(up_n),
      .lower_byte_enable_n_r(lo_n), .word_select_bit_r(ws), .bus_din(bus_din),
      .bus_ready_n(bus_ready_n), .half_width_bus_select_n(bs_n));
   bsa_mem16_model PART (.clock(clock), .cycle_start_n(cycle_start_n_r), .word_select_bit(ws),
      .size16(size16), .waits(waits), .mem(mem), .bus_din(bus_din), .bus_ready_n(bus_ready_n),
      .half_width_bus_select_n(bs_n));
   task stop_test();
      if (failures == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (!cycle_start_n_r) begin
         q.push_back({ws, up_n, lo_n, bus_doe_r, bus_be_n_r, bus_dout_r});
         qa.push_back({bus_write_r, bus_addr_r});
      end
      if (cycles == 3000) begin
         failures++;
         stop_test();
      end
   end
   task chk(input logic [39:0] got, input logic [39:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [3:0] be, input logic [31:0] wd);
      int n = 0;
      q.delete();
      qa.delete();
      req.write = wr;
      req.addr = {be, 26'h15A5A5A};
      req.be_n = be;
      req.wdata = wd;
      req_valid = 1'b1;
      while (req_ready_r !== 1'b1 && n < 40) begin
         @(negedge clock);
         n++;
      end
      @(negedge clock);
      req_valid = 1'b0;
      while (done_r !== 1'b1 && n < 40) begin
         @(negedge clock);
         n++;
      end
      chk({39'h0, done_r}, 40'h1);
      foreach (qa[j]) chk({9'h0, qa[j]}, {9'h0, wr, be, 26'h15A5A5A});
   endtask
   task automatic run(input logic s16);
      logic [6:0] e, e2;
      logic [3:0] b;
      logic [31:0] wd, m;
      logic two;
      size16 = s16;
      for (int i = 0; i < 10; i++) begin
         e = TBL[i];
         b = e[6:3];
         e2 = TBL[i < 6 ? 3 : 6 + (i == 8 || i == 9) * 1];
         e2 = {b | 4'h3, 3'h0};
         for (int k = 0; k < 10; k++) begin
            if (TBL[k][6:3] == (b | 4'h3)) e2 = TBL[k];
         end
         two = s16 && b[1:0] != 2'h3 && b[3:2] != 2'h3;
         wd = 32'hA1B2C3D4 ^ {8{b}};
         waits = 2'(i);
         xfer(1'b1, b, wd);
         chk(40'(q.size()), two ? 40'h2 : 40'h1);
         chk(q[0], {e[2:0], 1'b1, b, b[1:0] == 2'h3 ? {2{wd[31:16]}} : wd});
         if (two) chk(q[1], {e2[2:0], 1'b1, b | 4'h3, {2{wd[31:16]}}});
         xfer(1'b0, b, 32'h0);
         chk(40'(q.size()), two ? 40'h2 : 40'h1);
         chk({32'h0, q[0][39:32]}, {32'h0, e[2:0], 1'b0, b});
         if (two) chk({32'h0, q[1][39:32]}, {32'h0, e2[2:0], 1'b0, b | 4'h3});
         m = {{8{~b[3]}}, {8{~b[2]}}, {8{~b[1]}}, {8{~b[0]}}};
         chk({8'h0, done_rdata_r & m}, {8'h0, mem & m});
      end
   endtask
   task t_wide();
      run(1'b0);
   endtask
   task t_narrow();
      run(1'b1);
   endtask
   initial begin
      repeat (2) @(negedge clock);
      nrst = 1'b1;
      t_wide();
      t_narrow();
      stop_test();
   end
endmodule // bus_sizing_16bit_adapter_tb_top
